/* pkg/wdog_pkg.sv */
// shared constants and carrier types for the protected-write watchdog
package wdog_pkg;
  // register indices on the plain register port
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_COUNT = 2'h1;
  localparam logic [1:0] ADDR_CLKSEL = 2'h2;
  // control/status field positions
  localparam int CTL_COUNTER_GUARD = 7;
  localparam int CTL_COUNTER_WE = 6;
  localparam int CTL_CTRL_GUARD = 5;
  localparam int CTL_CTRL_WE = 4;
  localparam int CTL_RUN_GUARD = 3;
  localparam int CTL_RUN = 2;
  localparam int CTL_FLAG_GUARD = 1;
  localparam int CTL_FLAG = 0;
  // clock select layout
  localparam int SEL_TOP = 3;
  localparam logic [3:0] CLKSEL_RESET = 4'hF;
  localparam logic [3:0] CLKSEL_RSVD = 4'hF;
  // reset values and top count
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
  // prescaler: bit 5 has a period of 64 system clocks
  localparam int PRESCALE_W = 13;
  localparam logic [3:0] DIV_BASE_BIT = 4'h5;
  // internal reset length in oscillator cycles
  localparam int RESET_HOLD_OSC = 256;
  localparam logic [8:0] RESET_HOLD_LOAD = 9'(RESET_HOLD_OSC);

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } reg_req_type;
endpackage

/* design/protected_write_watchdog.sv */
// protected-write 8-bit watchdog with guarded control bits and clock select
`timescale 1ns/10ps
`default_nettype none

module protected_write_watchdog (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire wdog_pkg::reg_req_type reg_req,
  output logic [7:0] reg_rdata,
  input wire logic osc_clk_pin,
  output logic chip_reset_out,
  output logic run_out
);

  logic counter_we_reg;
  logic ctrl_we_reg;
  logic run_bit_reg;
  logic overflow_reset_flag_reg;
  logic [7:0] wdog_counter_reg;
  logic [3:0] clk_sel_reg;
  logic [wdog_pkg::PRESCALE_W-1:0] prescale_reg;
  logic div_prev_reg;
  logic osc_sync1_reg;
  logic osc_sync2_reg;
  logic osc_prev_reg;
  logic [8:0] hold_cnt_reg;
  logic chip_reset_reg;
  logic [7:0] rdata_reg;

  logic ctrl_wr;
  logic count_wr;
  logic sel_wr;
  logic [7:0] wd;
  logic [3:0] div_index;
  logic div_level;
  logic div_tick;
  logic osc_tick;
  logic sel_tick;
  logic count_tick;
  logic overflow;
  logic [7:0] ctrl_view;

  assign wd = reg_req.wdata;
  assign ctrl_wr = reg_req.write && (reg_req.addr == wdog_pkg::ADDR_CTRL);
  assign count_wr = reg_req.write && (reg_req.addr == wdog_pkg::ADDR_COUNT);
  assign sel_wr = reg_req.write && (reg_req.addr == wdog_pkg::ADDR_CLKSEL);

  // control write-enable guards
  // bit 7 gates counter enable
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      counter_we_reg <= 1'b0;
    end else if (ctrl_wr && !wd[wdog_pkg::CTL_COUNTER_GUARD]) begin
      counter_we_reg <= wd[wdog_pkg::CTL_COUNTER_WE];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_we_reg <= 1'b0;
    end else if (ctrl_wr && !wd[wdog_pkg::CTL_CTRL_GUARD]) begin
      ctrl_we_reg <= wd[wdog_pkg::CTL_CTRL_WE];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      run_bit_reg <= 1'b0;
    end else if (ctrl_wr && ctrl_we_reg && !wd[wdog_pkg::CTL_RUN_GUARD]) begin
      run_bit_reg <= wd[wdog_pkg::CTL_RUN];
    end
  end

  // set wins over a same-cycle clearing write
  // reset flag
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      overflow_reset_flag_reg <= 1'b0;
    end else if (overflow) begin
      overflow_reset_flag_reg <= 1'b1;
    end else if (ctrl_wr && ctrl_we_reg && !wd[wdog_pkg::CTL_FLAG_GUARD]) begin
      overflow_reset_flag_reg <= wd[wdog_pkg::CTL_FLAG];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clk_sel_reg <= wdog_pkg::CLKSEL_RESET;
    end else if (sel_wr) begin
      clk_sel_reg <= wd[3:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prescale_reg <= '0;
    end else begin
      prescale_reg <= prescale_reg + 1'b1;
    end
  end

  assign div_index = wdog_pkg::DIV_BASE_BIT + {1'b0, clk_sel_reg[2:0]};
  assign div_level = prescale_reg[div_index];

  // a select change can look like a rising edge and add one count
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      div_prev_reg <= 1'b0;
    end else begin
      div_prev_reg <= div_level;
    end
  end

  assign div_tick = div_level && !div_prev_reg;

  // oscillator pin is asynchronous: two flops before use
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      osc_sync1_reg <= 1'b0;
      osc_sync2_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
    end else begin
      osc_sync1_reg <= osc_clk_pin;
      osc_sync2_reg <= osc_sync1_reg;
      osc_prev_reg <= osc_sync2_reg;
    end
  end

  assign osc_tick = osc_sync2_reg && !osc_prev_reg;

  // top select bit zero picks oscillator
  assign sel_tick = clk_sel_reg[wdog_pkg::SEL_TOP] ? div_tick : osc_tick;

  assign count_tick = run_bit_reg && sel_tick;

  // a software write beats a coincident count, so no overflow then
  // wrap from the top count
  assign overflow = count_tick && !(count_wr && counter_we_reg)
                    && (wdog_counter_reg == wdog_pkg::COUNT_MAX);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wdog_counter_reg <= wdog_pkg::COUNT_RESET;
    end else if (count_wr && counter_we_reg) begin
      wdog_counter_reg <= wd;
    end else if (count_tick) begin
      wdog_counter_reg <= wdog_counter_reg + 8'h01;
    end
  end

  // a new overflow while held restarts the full length
  // hold internal reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hold_cnt_reg <= 9'h000;
    end else if (overflow) begin
      hold_cnt_reg <= wdog_pkg::RESET_HOLD_LOAD;
    end else if (osc_tick && (hold_cnt_reg != 9'h000)) begin
      hold_cnt_reg <= hold_cnt_reg - 9'h001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      chip_reset_reg <= 1'b0;
    end else if (overflow) begin
      chip_reset_reg <= 1'b1;
    end else if (osc_tick && (hold_cnt_reg == 9'h001)) begin
      chip_reset_reg <= 1'b0;
    end
  end

  assign ctrl_view = {1'b1, counter_we_reg, 1'b1, ctrl_we_reg,
                      1'b1, run_bit_reg, 1'b1, overflow_reset_flag_reg};

  // read data valid the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_reg <= wdog_pkg::RDATA_UNMAPPED;
    end else if (reg_req.read) begin
      unique case (reg_req.addr)
        wdog_pkg::ADDR_CTRL: begin
          rdata_reg <= ctrl_view;
        end
        wdog_pkg::ADDR_COUNT: begin
          rdata_reg <= wdog_counter_reg;
        end
        wdog_pkg::ADDR_CLKSEL: begin
          rdata_reg <= {wdog_pkg::CLKSEL_RSVD, clk_sel_reg};
        end
        default: begin
          rdata_reg <= wdog_pkg::RDATA_UNMAPPED;
        end
      endcase
    end else begin
      rdata_reg <= wdog_pkg::RDATA_UNMAPPED;
    end
  end

  assign reg_rdata = rdata_reg;
  assign chip_reset_out = chip_reset_reg;
  assign run_out = run_bit_reg;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  property p_counter_we_guard;
    ctrl_wr && wd[wdog_pkg::CTL_COUNTER_GUARD] |=> $stable(counter_we_reg);
  endproperty
  a_counter_we_guard: assert property (p_counter_we_guard)
    else $error("counter enable changed with guard written one");

  property p_count_write_blocked;
    count_wr && !counter_we_reg && !count_tick |=> $stable(wdog_counter_reg);
  endproperty
  a_count_write_blocked: assert property (p_count_write_blocked)
    else $error("counter written while enable clear");

  property p_ctrl_we_guard;
    ctrl_wr && wd[wdog_pkg::CTL_CTRL_GUARD] |=> $stable(ctrl_we_reg);
  endproperty
  a_ctrl_we_guard: assert property (p_ctrl_we_guard)
    else $error("control enable changed with guard written one");

  property p_run_protected;
    !(ctrl_wr && ctrl_we_reg && !wd[wdog_pkg::CTL_RUN_GUARD]) |=> $stable(run_bit_reg);
  endproperty
  a_run_protected: assert property (p_run_protected)
    else $error("run bit changed without permitted write");

  property p_run_loads;
    ctrl_wr && ctrl_we_reg && !wd[wdog_pkg::CTL_RUN_GUARD]
      |=> run_bit_reg == $past(wd[wdog_pkg::CTL_RUN]);
  endproperty
  a_run_loads: assert property (p_run_loads)
    else $error("run bit did not take permitted write");

  property p_flag_protected;
    $fell(overflow_reset_flag_reg) |-> $past(ctrl_wr && ctrl_we_reg)
      && !$past(wd[wdog_pkg::CTL_FLAG_GUARD]);
  endproperty
  a_flag_protected: assert property (p_flag_protected)
    else $error("reset flag cleared without permitted write");

  property p_guard_read;
    reg_req.read && reg_req.addr == wdog_pkg::ADDR_CTRL
      |=> reg_rdata[7] && reg_rdata[5] && reg_rdata[3] && reg_rdata[1];
  endproperty
  a_guard_read: assert property (p_guard_read)
    else $error("guard bit read as zero");

  property p_hold_stopped;
    !run_bit_reg && !count_wr |=> $stable(wdog_counter_reg);
  endproperty
  a_hold_stopped: assert property (p_hold_stopped)
    else $error("counter moved while stopped");

  property p_overflow_effects;
    overflow |=> overflow_reset_flag_reg && chip_reset_out
      && wdog_counter_reg == wdog_pkg::COUNT_RESET;
  endproperty
  a_overflow_effects: assert property (p_overflow_effects)
    else $error("overflow did not wrap, flag and reset");

  property p_reset_counter;
    !rst_n |=> wdog_counter_reg == wdog_pkg::COUNT_RESET;
  endproperty
  a_reset_counter: assert property (disable iff (1'b0) p_reset_counter)
    else $error("counter not zero after reset");

  property p_reset_hold_end;
    $fell(chip_reset_out) |-> $past(hold_cnt_reg) == 9'h001 && $past(osc_tick);
  endproperty
  a_reset_hold_end: assert property (p_reset_hold_end)
    else $error("internal reset ended early");

  property p_counter_we_loads;
    ctrl_wr && !wd[wdog_pkg::CTL_COUNTER_GUARD]
      |=> counter_we_reg == $past(wd[wdog_pkg::CTL_COUNTER_WE]);
  endproperty
  a_counter_we_loads: assert property (p_counter_we_loads)
    else $error("counter enable did not take permitted write");

  property p_ctrl_we_loads;
    ctrl_wr && !wd[wdog_pkg::CTL_CTRL_GUARD]
      |=> ctrl_we_reg == $past(wd[wdog_pkg::CTL_CTRL_WE]);
  endproperty
  a_ctrl_we_loads: assert property (p_ctrl_we_loads)
    else $error("control enable did not take permitted write");

  property p_count_load;
    count_wr && counter_we_reg |=> wdog_counter_reg == $past(wd);
  endproperty
  a_count_load: assert property (p_count_load)
    else $error("enabled counter write not taken");

  property p_count_step;
    count_tick && !(count_wr && counter_we_reg)
      |=> wdog_counter_reg == $past(wdog_counter_reg) + 8'h01;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("counter did not step on a tick");

  property p_flag_write_clear;
    ctrl_wr && ctrl_we_reg && !wd[wdog_pkg::CTL_FLAG_GUARD] && !wd[wdog_pkg::CTL_FLAG]
      && !overflow |=> !overflow_reset_flag_reg;
  endproperty
  a_flag_write_clear: assert property (p_flag_write_clear)
    else $error("reset flag not cleared by permitted write");

  property p_flag_reset_clear;
    !rst_n |=> !overflow_reset_flag_reg;
  endproperty
  a_flag_reset_clear: assert property (disable iff (1'b0) p_flag_reset_clear)
    else $error("reset flag not cleared by reset");

  property p_run_reset_clear;
    !rst_n |=> !run_bit_reg;
  endproperty
  a_run_reset_clear: assert property (disable iff (1'b0) p_run_reset_clear)
    else $error("run bit not cleared by reset");

  property p_clksel_read;
    reg_req.read && reg_req.addr == wdog_pkg::ADDR_CLKSEL
      |=> reg_rdata[7:4] == wdog_pkg::CLKSEL_RSVD;
  endproperty
  a_clksel_read: assert property (p_clksel_read)
    else $error("reserved select bits read as zero");

  property p_osc_source;
    run_bit_reg && !clk_sel_reg[wdog_pkg::SEL_TOP] && !osc_tick && !count_wr
      |=> $stable(wdog_counter_reg);
  endproperty
  a_osc_source: assert property (p_osc_source)
    else $error("counter moved without oscillator edge");

  property p_div_source;
    run_bit_reg && clk_sel_reg[wdog_pkg::SEL_TOP] && !div_tick && !count_wr
      |=> $stable(wdog_counter_reg);
  endproperty
  a_div_source: assert property (p_div_source)
    else $error("counter moved without division edge");

  property p_reset_load;
    overflow |=> hold_cnt_reg == wdog_pkg::RESET_HOLD_LOAD;
  endproperty
  a_reset_load: assert property (p_reset_load)
    else $error("internal reset length not loaded");

endmodule // protected_write_watchdog

`default_nettype wire

/* verif/protected_write_watchdog_bench.sv */
// register-level bench for the protected-write watchdog
`timescale 1ns/10ps
`default_nettype none

module protected_write_watchdog_bench;
  logic core_clk;
  logic rst_n;
  logic osc_clk_pin;
  wdog_pkg::reg_req_type req;
  logic [7:0] reg_rdata;
  logic chip_reset_out;
  logic run_out;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] v;
  int n;

  protected_write_watchdog u_dut (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .reg_req(req),
    .reg_rdata(reg_rdata),
    .osc_clk_pin(osc_clk_pin),
    .chip_reset_out(chip_reset_out),
    .run_out(run_out)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // oscillator well below a quarter of the system clock
  initial begin
    osc_clk_pin = 1'b0;
    forever #30 osc_clk_pin = ~osc_clk_pin;
  end

  task automatic end_of_test;
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      mismatches = mismatches + 1;
      end_of_test();
    end
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    @(posedge core_clk);
    req.write <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge core_clk);
    req <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
    @(posedge core_clk);
    req.read <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rdc(input logic [1:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    cmp(16'(d), 16'(exp));
  endtask

  task automatic do_reset;
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    rdc(wdog_pkg::ADDR_CTRL, 8'hAA);
    rdc(wdog_pkg::ADDR_COUNT, 8'h00);
    rdc(wdog_pkg::ADDR_CLKSEL, 8'hFF);
  endtask

  // one tick period of a division, read-poll granularity is two cycles
  task automatic period(input logic [3:0] code);
    logic [7:0] v0;
    logic [7:0] d;
    int k;
    int p;
    p = 64 << code[2:0];
    wr(wdog_pkg::ADDR_CLKSEL, {4'hF, code});
    wr(wdog_pkg::ADDR_COUNT, 8'h00);
    rd(wdog_pkg::ADDR_COUNT, v0);
    d = v0;
    k = 0;
    while (d === v0 && k < 20000) begin
      rd(wdog_pkg::ADDR_COUNT, d);
      k++;
    end
    v0 = d;
    k = 0;
    while (d === v0 && k < 20000) begin
      rd(wdog_pkg::ADDR_COUNT, d);
      k += 2;
    end
    cmp(16'((k >= p - 2 && k <= p + 2) ? p : k), 16'(p));
  endtask

  initial begin
    rst_n = 1'b0;
    req = '{addr: 2'h0, wdata: 8'h00, write: 1'b0, read: 1'b0};
    do_reset();
    rdc(2'h3, 8'h00);
    wr(wdog_pkg::ADDR_COUNT, 8'h55);
    rdc(wdog_pkg::ADDR_COUNT, 8'h00);
    wr(wdog_pkg::ADDR_CTRL, 8'hFF);
    rdc(wdog_pkg::ADDR_CTRL, 8'hAA);
    wr(wdog_pkg::ADDR_CTRL, 8'h7F);
    rdc(wdog_pkg::ADDR_CTRL, 8'hEA);
    // run request while control writes are still locked
    wr(wdog_pkg::ADDR_CTRL, 8'hF4);
    rdc(wdog_pkg::ADDR_CTRL, 8'hEA);
    wr(wdog_pkg::ADDR_CTRL, 8'hDF);
    wr(wdog_pkg::ADDR_CTRL, 8'hFF);
    rdc(wdog_pkg::ADDR_CTRL, 8'hFA);
    wr(wdog_pkg::ADDR_CTRL, 8'hB6);
    rdc(wdog_pkg::ADDR_CTRL, 8'hFE);
    cmp(16'(run_out), 16'h0001);
    for (int c = 8; c < 16; c++) period(4'(c));
    // overflow from a preset value, three ticks of div 64
    wr(wdog_pkg::ADDR_CLKSEL, 8'h08);
    wr(wdog_pkg::ADDR_COUNT, 8'hFD);
    n = 0;
    while (chip_reset_out !== 1'b1 && n < 400) begin
      @(posedge core_clk);
      n++;
    end
    cmp(16'(n > 64 && n < 260), 16'h0001);
    rdc(wdog_pkg::ADDR_COUNT, 8'h00);
    rdc(wdog_pkg::ADDR_CTRL, 8'hFF);
    // reset pulse of 256 oscillator periods of six cycles
    n = 0;
    while (chip_reset_out === 1'b1 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    cmp(16'((n > 1520 && n < 1550) ? 1536 : n), 16'd1536);
    // flag write with its guard set must not clear it
    wr(wdog_pkg::ADDR_CTRL, 8'hFE);
    rdc(wdog_pkg::ADDR_CTRL, 8'hFF);
    wr(wdog_pkg::ADDR_CTRL, 8'hFC);
    rdc(wdog_pkg::ADDR_CTRL, 8'hFE);
    wr(wdog_pkg::ADDR_CTRL, 8'hF2);
    rdc(wdog_pkg::ADDR_CTRL, 8'hFA);
    rd(wdog_pkg::ADDR_COUNT, v);
    repeat (200) @(posedge core_clk);
    rdc(wdog_pkg::ADDR_COUNT, v);
    // oscillator source: about 33 ticks in 200 cycles
    wr(wdog_pkg::ADDR_CLKSEL, 8'h00);
    rdc(wdog_pkg::ADDR_CLKSEL, 8'hF0);
    wr(wdog_pkg::ADDR_COUNT, 8'h00);
    wr(wdog_pkg::ADDR_CTRL, 8'hF6);
    repeat (200) @(posedge core_clk);
    rd(wdog_pkg::ADDR_COUNT, v);
    cmp(16'(v > 8'h1C && v < 8'h26), 16'h0001);
    // second overflow, so that the external reset must clear a set flag
    wr(wdog_pkg::ADDR_COUNT, 8'hFE);
    n = 0;
    while (chip_reset_out !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    cmp(16'(chip_reset_out), 16'h0001);
    rdc(wdog_pkg::ADDR_CTRL, 8'hFF);
    // external reset in mid-run, run bit and flag both set
    do_reset();
    cmp(16'(run_out), 16'h0000);
    end_of_test();
  end
endmodule // protected_write_watchdog_bench
`default_nettype wire
